/* asd_params.svh */
/*
 * Register offsets, field positions, reset values, codes and sizes
 * for the free-format serial character driver.
 * Assumes byte addresses on a 32-bit Avalon-MM slave port.
 */
`ifndef ASD_PARAMS_SVH
`define ASD_PARAMS_SVH
// Register byte offsets
`define ASD_OFS_SEND_COORD 8'h00
`define ASD_OFS_RECV_COORD 8'h04
`define ASD_OFS_CONFIG 8'h08
`define ASD_OFS_BAUD_DIV 8'h0C
`define ASD_OFS_CHAR_DELAY 8'h10
`define ASD_OFS_SMB_PTR 8'h14
`define ASD_OFS_SMB_DATA 8'h18
`define ASD_OFS_RMB_PTR 8'h1C
`define ASD_OFS_RMB_DATA 8'h20
`define ASD_OFS_RMB_LEN 8'h24
`define ASD_OFS_STATUS 8'h28
// Coordination byte fields
`define ASD_PERMIT_BIT 7
`define ASD_CODE_LSB 8
// Configuration fields
`define ASD_CFG_MODE_LSB 0
`define ASD_CFG_PAR_LSB 4
`define ASD_CFG_DBITS_LSB 8
`define ASD_CFG_STOP2_BIT 12
`define ASD_CFG_EN_BIT 13
`define ASD_CFG_SMB_OK_BIT 14
`define ASD_CFG_RMB_OK_BIT 15
`define ASD_CFG_ENDCH_LSB 16
`define ASD_CFG_FLOW_BIT 24
// Reset values
`define ASD_CFG_RST 32'h000DE801
`define ASD_BAUD_RST 16'h32DC
`define ASD_DELAY_RST 16'h0014
// Parity encodings
`define ASD_PAR_NONE 3'h0
`define ASD_PAR_EVEN 3'h1
`define ASD_PAR_ODD 3'h2
`define ASD_PAR_MARK 3'h3
`define ASD_PAR_SPACE 3'h4
// Status codes
`define ASD_C_OK 8'h00
`define ASD_S_OBUF_FULL 8'h07
`define ASD_S_PARAM 8'h0D
`define ASD_S_NO_MBOX 8'h11
`define ASD_S_TOO_LONG 8'h13
`define ASD_C_BREAK 8'h1B
`define ASD_R_DELAY 8'h01
`define ASD_R_PARITY 8'h03
`define ASD_R_AFTER_XOFF 8'h05
`define ASD_R_IBUF_FULL 8'h07
`define ASD_R_TOO_MANY 8'h09
`define ASD_R_TOO_BIG 8'h0B
`define ASD_R_NO_MBOX 8'h0F
// Flow characters
`define ASD_CH_XON 8'h11
`define ASD_CH_XOFF 8'h13
`define ASD_CH_RUBOUT 8'h7F
// Sizes and levels
`define ASD_IBUF_DEPTH 1024
`define ASD_FRAME_MAX 100
`define ASD_XOFF_LEVEL 960
`define ASD_XON_LEVEL 512
`endif

/* asd_pkg.sv */
/*
 * State encodings of the serial character driver.
 * Assumes nothing beyond a SystemVerilog elaborator.
 */
package asd_pkg;
	// Send sequencer
	typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_COPY = 3'b010, TX_SEND = 3'b100} tx_st_t;
	// Receive bit sampler
	typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_SAMPLE = 2'b10} rx_st_t;
	// Input buffer to mailbox mover
	typedef enum logic [1:0] {XF_IDLE = 2'b01, XF_COPY = 2'b10} xf_st_t;
endpackage

/* asd_serial_driver.sv */
/*
 * Free-format serial character driver: send mailbox, output buffer,
 * line transmitter and receiver, input buffer, receive mailbox, and two
 * coordination bytes, all behind an Avalon-MM slave with waitrequest.
 * Assumes one clock, an active-low asynchronous reset and an idle-high line.
 */
`include "asd_params.svh"
module asd_serial_driver #(
	parameter int IBUF_DEPTH = `ASD_IBUF_DEPTH,
	parameter int FRAME_MAX = `ASD_FRAME_MAX,
	parameter int XOFF_LEVEL = `ASD_XOFF_LEVEL,
	parameter int XON_LEVEL = `ASD_XON_LEVEL,
	parameter int SMB_DEPTH = 64,
	parameter int OBUF_DEPTH = 64,
	parameter int RMB_DEPTH = 64
) (
	// Clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic RESETN_IN,
	// Avalon-MM slave
	input wire logic [7:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	// Serial line, idle high
	input wire logic RXD_IN,
	output logic TXD_OUT
);
	localparam int IW = $clog2(IBUF_DEPTH);
	localparam int FW = $clog2(FRAME_MAX);
	localparam int SIW = $clog2(SMB_DEPTH);
	localparam int SPW = $clog2(SMB_DEPTH + 1);
	localparam int OW = $clog2(OBUF_DEPTH);
	localparam int RIW = $clog2(RMB_DEPTH);

	// Whole module state
	typedef struct packed {
		logic waitreq;
		logic [31:0] rdata;
		logic snd_perm;
		logic snd_prev;
		logic [7:0] snd_code;
		logic rcv_perm;
		logic [7:0] rcv_code;
		logic [31:0] cfg;
		logic [15:0] baud;
		logic [15:0] cdel;
		logic [SMB_DEPTH-1:0][7:0] smb;
		logic [SPW-1:0] smb_ptr;
		logic [OBUF_DEPTH-1:0][7:0] obuf;
		asd_pkg::tx_st_t tx_st;
		logic [15:0] tx_len;
		logic [15:0] tx_idx;
		logic [1:0] tx_base;
		logic tx_busy;
		logic [11:0] tx_sh;
		logic [3:0] tx_left;
		logic [15:0] tx_cnt;
		logic txd;
		logic xoff_sent;
		logic flow_pend;
		logic [7:0] flow_ch;
		logic remote_stop;
		logic rx_s1;
		logic rx_s2;
		asd_pkg::rx_st_t rx_st;
		logic [15:0] rx_cnt;
		logic [3:0] rx_idx;
		logic [11:0] rx_sh;
		logic [15:0] gap;
		logic [15:0] gap_cyc;
		logic [IBUF_DEPTH-1:0][7:0] ibuf;
		logic [IW-1:0] wr_ptr;
		logic [IW-1:0] rd_ptr;
		logic [IW-1:0] fstart;
		logic [IW:0] fill;
		logic [IW:0] cur_len;
		logic [FRAME_MAX-1:0][IW:0] flens;
		logic [FW-1:0] fwr;
		logic [FW-1:0] frd;
		logic [FW:0] frames;
		logic [RMB_DEPTH-1:0][7:0] rmb;
		logic [RIW-1:0] rmb_ptr;
		logic [IW:0] rmb_len;
		asd_pkg::xf_st_t xf_st;
		logic [IW:0] xf_left;
		logic [RIW-1:0] xf_pos;
	} asd_st_t;

	asd_st_t st_q; // Registered state
	asd_st_t st_d; // Next state

	// Parity bit over the low nb data bits
	function automatic logic par_of(input logic [7:0] d, input logic [3:0] nb,
			input logic [2:0] pm);
		logic [7:0] m;
		m = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (i < nb) m[i] = d[i];
		end
		unique case (pm)
			`ASD_PAR_EVEN: par_of = ^m;
			`ASD_PAR_ODD: par_of = ~^m;
			`ASD_PAR_MARK: par_of = 1'b1;
			default: par_of = 1'b0;
		endcase
	endfunction

	// Character frame, bit 0 goes on the line first
	function automatic logic [11:0] frame_of(input logic [7:0] d, input logic [3:0] nb,
			input logic [2:0] pm);
		logic [11:0] f;
		f = 12'hFFF;
		f[0] = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (i < nb) f[i + 1] = d[i];
		end
		if (pm != `ASD_PAR_NONE) f[nb + 4'h1] = par_of(d, nb, pm);
		return f;
	endfunction

	// Bits per character frame
	function automatic logic [3:0] frame_len(input logic [3:0] nb, input logic [2:0] pm,
			input logic st2);
		return 4'h2 + nb + {3'h0, pm != `ASD_PAR_NONE} + {3'h0, st2};
	endfunction

	// Next frame slot, ring of FRAME_MAX
	function automatic logic [FW-1:0] fnext(input logic [FW-1:0] f);
		return (f == FW'(FRAME_MAX - 1)) ? '0 : f + 1'b1;
	endfunction

	// Discard the partly received frame
	function automatic asd_st_t reject_cur(input asd_st_t s);
		s.wr_ptr = s.fstart;
		s.fill = s.fill - s.cur_len;
		s.cur_len = '0;
		return s;
	endfunction

	// Close the frame being received
	function automatic asd_st_t close_cur(input asd_st_t s);
		s.flens[s.fwr] = s.cur_len;
		s.fwr = fnext(s.fwr);
		s.frames = s.frames + 1'b1;
		s.cur_len = '0;
		s.fstart = s.wr_ptr;
		return s;
	endfunction

	// Drop the oldest stored frame
	function automatic asd_st_t drop_old(input asd_st_t s);
		s.rd_ptr = s.rd_ptr + s.flens[s.frd][IW-1:0];
		s.fill = s.fill - s.flens[s.frd];
		s.frd = fnext(s.frd);
		s.frames = s.frames - 1'b1;
		return s;
	endfunction

	// Configuration fields
	wire logic [3:0] mode = st_q.cfg[`ASD_CFG_MODE_LSB +: 4];
	wire logic [2:0] pm = st_q.cfg[`ASD_CFG_PAR_LSB +: 3];
	wire logic [3:0] nb = st_q.cfg[`ASD_CFG_DBITS_LSB +: 4];
	wire logic st2 = st_q.cfg[`ASD_CFG_STOP2_BIT];
	wire logic en = st_q.cfg[`ASD_CFG_EN_BIT];
	wire logic flow = st_q.cfg[`ASD_CFG_FLOW_BIT];
	wire logic [7:0] endch = st_q.cfg[`ASD_CFG_ENDCH_LSB +: 8];
	wire logic [3:0] flen = frame_len(nb, pm, st2);
	// Bus handshake terms, send permit edge and end of received character
	wire logic acc = (AVS_READ_IN || AVS_WRITE_IN) && !st_q.waitreq;
	wire logic sw_snd_wr = acc && AVS_WRITE_IN && AVS_ADDRESS_IN == `ASD_OFS_SEND_COORD;
	wire logic sw_rcv_wr = acc && AVS_WRITE_IN && AVS_ADDRESS_IN == `ASD_OFS_RECV_COORD;
	wire logic snd_edge = st_q.snd_perm && !st_q.snd_prev;
	wire logic rx_fin = st_q.rx_st == asd_pkg::RX_SAMPLE && st_q.rx_cnt == 16'h0000 &&
		st_q.rx_idx == flen - 4'h1;

	// Next-state logic
	always_comb begin
		logic [11:0] sh;
		logic [7:0] c;
		logic perr;
		logic [15:0] len;
		sh = st_q.rx_sh;
		c = 8'h00;
		perr = 1'b0;
		len = 16'h0000;
		st_d = st_q;
		st_d.snd_prev = st_q.snd_perm;
		// Bus answer: one wait cycle, then a single ready cycle
		st_d.waitreq = !((AVS_READ_IN || AVS_WRITE_IN) && st_q.waitreq);
		if (AVS_READ_IN && st_q.waitreq) begin
			st_d.rdata = 32'h00000000;
			unique case (AVS_ADDRESS_IN)
				`ASD_OFS_SEND_COORD: st_d.rdata = {16'h0000, st_q.snd_code, st_q.snd_perm, 7'h00};
				`ASD_OFS_RECV_COORD: st_d.rdata = {16'h0000, st_q.rcv_code, st_q.rcv_perm, 7'h00};
				`ASD_OFS_CONFIG: st_d.rdata = st_q.cfg;
				`ASD_OFS_BAUD_DIV: st_d.rdata = {16'h0000, st_q.baud};
				`ASD_OFS_CHAR_DELAY: st_d.rdata = {16'h0000, st_q.cdel};
				`ASD_OFS_SMB_PTR: st_d.rdata = 32'(st_q.smb_ptr);
				`ASD_OFS_RMB_PTR: st_d.rdata = 32'(st_q.rmb_ptr);
				`ASD_OFS_RMB_DATA: st_d.rdata = {24'h000000, st_q.rmb[st_q.rmb_ptr]};
				`ASD_OFS_RMB_LEN: st_d.rdata = 32'(st_q.rmb_len);
				`ASD_OFS_STATUS: st_d.rdata = {5'h00, st_q.remote_stop, st_q.xoff_sent,
					st_q.tx_busy, 8'(st_q.frames), 5'h00, 11'(st_q.fill)};
				default: st_d.rdata = 32'h00000000; // Unmapped reads as zero
			endcase
		end
		// Send sequencer; a received break aborts it, a received XOFF holds it
		unique case (st_q.tx_st)
			asd_pkg::TX_IDLE: begin
				if (snd_edge && en) begin
					len = (mode == 4'h1 || mode == 4'h7 || mode == 4'h8) ?
						{st_q.smb[0], st_q.smb[1]} : 16'(st_q.smb_ptr);
					st_d.tx_base = (mode == 4'h1 || mode == 4'h7 || mode == 4'h8) ? 2'h2 : 2'h0;
					st_d.snd_perm = 1'b0;
					if (mode == 4'h0 || mode > 4'h8 || nb < 4'h5 || nb > 4'h8 ||
							pm > `ASD_PAR_SPACE || st_q.baud == 16'h0000) begin
						st_d.snd_code = `ASD_S_PARAM;
					end else if (!st_q.cfg[`ASD_CFG_SMB_OK_BIT]) begin
						st_d.snd_code = `ASD_S_NO_MBOX;
					end else if (32'(len) > OBUF_DEPTH ||
							32'(len) + 32'(st_d.tx_base) > SMB_DEPTH) begin
						st_d.snd_code = `ASD_S_TOO_LONG;
					end else begin
						st_d.snd_perm = 1'b1;
						st_d.snd_code = `ASD_C_OK;
						st_d.tx_len = len;
						st_d.tx_idx = 16'h0000;
						st_d.tx_st = asd_pkg::TX_COPY;
					end
				end
			end
			asd_pkg::TX_COPY: begin
				if (snd_edge) st_d.snd_code = `ASD_S_OBUF_FULL;
				if (st_q.tx_idx == st_q.tx_len) begin
					st_d.tx_idx = 16'h0000;
					st_d.tx_st = asd_pkg::TX_SEND;
				end else begin
					// Mailbox into output buffer first
					st_d.obuf[st_q.tx_idx[OW-1:0]] =
						st_q.smb[SIW'(st_q.tx_idx + 16'(st_q.tx_base))];
					st_d.tx_idx = st_q.tx_idx + 16'h0001;
				end
			end
			asd_pkg::TX_SEND: begin
				if (snd_edge) st_d.snd_code = `ASD_S_OBUF_FULL;
				if (st_q.tx_idx == st_q.tx_len && !st_q.tx_busy) begin
					st_d.snd_perm = 1'b0;
					st_d.tx_st = asd_pkg::TX_IDLE;
				end else if (st_q.tx_idx != st_q.tx_len && !st_q.tx_busy &&
						!st_q.flow_pend && !st_q.remote_stop) begin
					// Send data fed to the line only from the output buffer
					st_d.tx_sh = frame_of(st_q.obuf[st_q.tx_idx[OW-1:0]], nb, pm);
					st_d.tx_left = flen;
					st_d.tx_cnt = st_q.baud - 16'h0001;
					st_d.tx_busy = 1'b1;
					st_d.txd = 1'b0;
					st_d.tx_idx = st_q.tx_idx + 16'h0001;
				end
			end
			default: st_d.tx_st = asd_pkg::TX_IDLE;
		endcase
		// Line shifter; a pending flow character goes first
		if (!st_q.tx_busy && st_q.flow_pend) begin
			st_d.tx_sh = frame_of(st_q.flow_ch, nb, pm);
			st_d.tx_left = flen;
			st_d.tx_cnt = st_q.baud - 16'h0001;
			st_d.tx_busy = 1'b1;
			st_d.txd = 1'b0;
			st_d.flow_pend = 1'b0;
		end else if (st_q.tx_busy) begin
			if (st_q.tx_cnt != 16'h0000) begin
				st_d.tx_cnt = st_q.tx_cnt - 16'h0001;
			end else if (st_q.tx_left == 4'h1) begin
				st_d.tx_busy = 1'b0;
				st_d.txd = 1'b1;
			end else begin
				st_d.tx_sh = {1'b1, st_q.tx_sh[11:1]};
				st_d.txd = st_q.tx_sh[1];
				st_d.tx_left = st_q.tx_left - 4'h1;
				st_d.tx_cnt = st_q.baud - 16'h0001;
			end
		end
		// Mover from input buffer to receive mailbox, on request only
		unique case (st_q.xf_st)
			asd_pkg::XF_IDLE: begin
				if (st_q.rcv_perm && st_q.frames != '0) begin
					if (!st_q.cfg[`ASD_CFG_RMB_OK_BIT]) begin
						st_d = drop_old(st_d);
						st_d.rcv_code = `ASD_R_NO_MBOX;
						st_d.rcv_perm = 1'b0;
					end else if (32'(st_q.flens[st_q.frd]) > RMB_DEPTH) begin
						st_d = drop_old(st_d);
						st_d.rcv_code = `ASD_R_TOO_BIG;
						st_d.rcv_perm = 1'b0;
					end else if (st_q.flens[st_q.frd] == '0) begin
						st_d = drop_old(st_d);
					end else begin
						st_d.xf_left = st_q.flens[st_q.frd];
						st_d.rmb_len = st_q.flens[st_q.frd];
						st_d.xf_pos = '0;
						st_d.xf_st = asd_pkg::XF_COPY;
					end
				end
			end
			asd_pkg::XF_COPY: begin
				st_d.rmb[st_q.xf_pos] = st_q.ibuf[st_q.rd_ptr];
				st_d.rd_ptr = st_q.rd_ptr + 1'b1;
				st_d.fill = st_d.fill - 1'b1;
				st_d.xf_pos = st_q.xf_pos + 1'b1;
				st_d.xf_left = st_q.xf_left - 1'b1;
				if (st_q.xf_left == (IW + 1)'(1)) begin
					st_d.frd = fnext(st_q.frd);
					st_d.frames = st_d.frames - 1'b1;
					st_d.rcv_code = `ASD_C_OK;
					st_d.rcv_perm = 1'b0;
					st_d.rmb_ptr = '0;
					st_d.xf_st = asd_pkg::XF_IDLE;
				end
			end
			default: st_d.xf_st = asd_pkg::XF_IDLE;
		endcase
		// Receiver: two-stage line synchroniser, then bit sampler
		st_d.rx_s1 = RXD_IN;
		st_d.rx_s2 = st_q.rx_s1;
		unique case (st_q.rx_st)
			asd_pkg::RX_IDLE: begin
				if (en && !st_q.rx_s2) begin
					st_d.rx_cnt = {1'b0, st_q.baud[15:1]};
					st_d.rx_idx = 4'h0;
					st_d.rx_st = asd_pkg::RX_SAMPLE;
				end
			end
			asd_pkg::RX_SAMPLE: begin
				if (st_q.rx_cnt != 16'h0000) begin
					st_d.rx_cnt = st_q.rx_cnt - 16'h0001;
				end else begin
					sh[st_q.rx_idx] = st_q.rx_s2;
					st_d.rx_sh = sh;
					st_d.rx_cnt = st_q.baud - 16'h0001;
					st_d.rx_idx = st_q.rx_idx + 4'h1;
					if (rx_fin) st_d.rx_st = asd_pkg::RX_IDLE;
				end
			end
			default: st_d.rx_st = asd_pkg::RX_IDLE;
		endcase
		// Whole character received
		if (rx_fin) begin
			for (int i = 0; i < 8; i++) begin
				if (i < nb) c[i] = sh[i + 1];
			end
			perr = sh[0] || !sh[flen - 4'h1] ||
				(pm != `ASD_PAR_NONE && sh[nb + 4'h1] != par_of(c, nb, pm));
			st_d.gap = 16'h0000;
			st_d.gap_cyc = 16'h0000;
			if (sh == 12'h000) begin
				st_d = reject_cur(st_d);
				st_d.rcv_code = `ASD_C_BREAK;
				st_d.rcv_perm = 1'b0;
				if (st_q.tx_st != asd_pkg::TX_IDLE) begin
					st_d.snd_code = `ASD_C_BREAK;
					st_d.snd_perm = 1'b0;
					st_d.tx_st = asd_pkg::TX_IDLE;
				end
			end else if (perr) begin
				st_d = reject_cur(st_d);
				st_d.rcv_code = `ASD_R_PARITY;
				st_d.rcv_perm = 1'b0;
			end else if (flow && (c == `ASD_CH_XON || c == `ASD_CH_XOFF)) begin
				st_d.remote_stop = c == `ASD_CH_XOFF;
			end else if (flow && c == `ASD_CH_RUBOUT && st_q.cur_len != '0) begin
				st_d.wr_ptr = st_q.wr_ptr - 1'b1;
				st_d.fill = st_d.fill - 1'b1;
				st_d.cur_len = st_q.cur_len - 1'b1;
			end else if (32'(st_q.frames) >= FRAME_MAX) begin
				st_d.rcv_code = `ASD_R_TOO_MANY;
				st_d.rcv_perm = 1'b0;
			end else if (32'(st_q.fill) >= IBUF_DEPTH) begin
				st_d = reject_cur(st_d);
				st_d.rcv_code = st_q.xoff_sent ? `ASD_R_AFTER_XOFF : `ASD_R_IBUF_FULL;
				st_d.rcv_perm = 1'b0;
			end else begin
				// Stored whatever the receive permit says
				st_d.ibuf[st_q.wr_ptr] = c;
				st_d.wr_ptr = st_q.wr_ptr + 1'b1;
				st_d.fill = st_d.fill + 1'b1;
				st_d.cur_len = st_q.cur_len + 1'b1;
				if (c == endch) st_d = close_cur(st_d);
			end
		end else if (st_q.cur_len != '0 && st_q.rx_st == asd_pkg::RX_IDLE) begin
			// Character delay counted in bit times
			st_d.gap_cyc = st_q.gap_cyc + 16'h0001;
			if (st_q.gap_cyc >= st_q.baud - 16'h0001) begin
				st_d.gap_cyc = 16'h0000;
				st_d.gap = st_q.gap + 16'h0001;
			end
			if (st_q.gap >= st_q.cdel && 32'(st_q.frames) < FRAME_MAX) begin
				st_d = close_cur(st_d);
				st_d.rcv_code = `ASD_R_DELAY;
				st_d.rcv_perm = 1'b0;
				st_d.gap = 16'h0000;
			end
		end
		// Flow control towards the partner
		if (flow && !st_q.xoff_sent && 32'(st_q.fill) >= XOFF_LEVEL) begin
			st_d.flow_ch = `ASD_CH_XOFF;
			st_d.flow_pend = 1'b1;
			st_d.xoff_sent = 1'b1;
		end else if (st_q.xoff_sent && !st_q.flow_pend && 32'(st_q.fill) < XON_LEVEL) begin
			st_d.flow_ch = `ASD_CH_XON;
			st_d.flow_pend = flow;
			st_d.xoff_sent = 1'b0;
		end
		if (!flow) st_d.remote_stop = 1'b0;
		// Port released: line idle, shifter stopped
		if (!en) begin
			st_d.tx_busy = 1'b0;
			st_d.txd = 1'b1;
			st_d.flow_pend = 1'b0;
		end
		// Register writes; a software permit write lands last
		if (acc && AVS_WRITE_IN) begin
			unique case (AVS_ADDRESS_IN)
				`ASD_OFS_SEND_COORD: st_d.snd_perm = AVS_WRITEDATA_IN[`ASD_PERMIT_BIT];
				`ASD_OFS_RECV_COORD: st_d.rcv_perm = AVS_WRITEDATA_IN[`ASD_PERMIT_BIT];
				`ASD_OFS_CONFIG: st_d.cfg = AVS_WRITEDATA_IN;
				`ASD_OFS_BAUD_DIV: st_d.baud = AVS_WRITEDATA_IN[15:0];
				`ASD_OFS_CHAR_DELAY: st_d.cdel = AVS_WRITEDATA_IN[15:0];
				`ASD_OFS_SMB_PTR: st_d.smb_ptr = AVS_WRITEDATA_IN[SPW-1:0];
				`ASD_OFS_SMB_DATA: begin
					if (32'(st_q.smb_ptr) < SMB_DEPTH) begin
						st_d.smb[st_q.smb_ptr[SIW-1:0]] = AVS_WRITEDATA_IN[7:0];
						st_d.smb_ptr = st_q.smb_ptr + 1'b1;
					end
				end
				`ASD_OFS_RMB_PTR: st_d.rmb_ptr = AVS_WRITEDATA_IN[RIW-1:0];
				default: ; // Other writes ignored
			endcase
		end
		// Reading mailbox data advances the pointer
		if (acc && AVS_READ_IN && AVS_ADDRESS_IN == `ASD_OFS_RMB_DATA) begin
			st_d.rmb_ptr = st_q.rmb_ptr + 1'b1;
		end
	end

	// State register
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			st_q <= '0;
			st_q.waitreq <= 1'b1;
			st_q.cfg <= `ASD_CFG_RST;
			st_q.baud <= `ASD_BAUD_RST;
			st_q.cdel <= `ASD_DELAY_RST;
			st_q.tx_st <= asd_pkg::TX_IDLE;
			st_q.rx_st <= asd_pkg::RX_IDLE;
			st_q.xf_st <= asd_pkg::XF_IDLE;
			st_q.txd <= 1'b1;
			st_q.rx_s1 <= 1'b1;
			st_q.rx_s2 <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from flops
	assign AVS_READDATA_OUT = st_q.rdata;
	assign AVS_WAITREQUEST_OUT = st_q.waitreq;
	assign TXD_OUT = st_q.txd;

	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RESETN_IN);

	send_start_a: assert property (snd_edge && en && st_q.tx_st == asd_pkg::TX_IDLE |=>
		st_q.tx_st == asd_pkg::TX_COPY || st_q.snd_code != `ASD_C_OK)
		else $error("send did not start on permit edge");
	send_done_a: assert property (st_q.tx_st == asd_pkg::TX_SEND &&
		st_q.tx_idx == st_q.tx_len && !st_q.tx_busy && !sw_snd_wr && !rx_fin |=>
		!st_q.snd_perm && st_q.tx_st == asd_pkg::TX_IDLE)
		else $error("send permit not cleared at end");
	recv_done_a: assert property (st_q.xf_st == asd_pkg::XF_COPY &&
		st_q.xf_left == (IW + 1)'(1) && !sw_rcv_wr && !rx_fin |=>
		!st_q.rcv_perm && st_q.rcv_code == `ASD_C_OK)
		else $error("receive permit not cleared after move");
	fill_cap_a: assert property (32'(st_q.fill) <= IBUF_DEPTH)
		else $error("input buffer overfilled");
	full_drop_a: assert property (rx_fin && 32'(st_q.fill) >= IBUF_DEPTH &&
		st_q.xf_st == asd_pkg::XF_IDLE && !st_q.rcv_perm |=> st_q.fill <= $past(st_q.fill))
		else $error("character stored into full buffer");
	busy_reject_a: assert property (snd_edge && st_q.tx_st != asd_pkg::TX_IDLE &&
		!rx_fin |=> st_q.snd_code == `ASD_S_OBUF_FULL)
		else $error("busy send not rejected");
	frame_cap_a: assert property (32'(st_q.frames) <= FRAME_MAX)
		else $error("too many frames held");
	no_rmb_a: assert property (st_q.xf_st == asd_pkg::XF_IDLE && st_q.rcv_perm &&
		st_q.frames != '0 && !st_q.cfg[`ASD_CFG_RMB_OK_BIT] && !rx_fin && !sw_rcv_wr |=>
		st_q.rcv_code == `ASD_R_NO_MBOX && !st_q.rcv_perm)
		else $error("missing receive mailbox not reported");
	line_off_a: assert property (!en |=> st_q.txd ##1 st_q.txd || en)
		else $error("line driven while port released");
	bus_pulse_a: assert property (!st_q.waitreq |=> st_q.waitreq)
		else $error("waitrequest low for more than one cycle");
	send_end_c: cover property (st_q.tx_st == asd_pkg::TX_SEND ##1 st_q.tx_st == asd_pkg::TX_IDLE);
	move_end_c: cover property (st_q.xf_st == asd_pkg::XF_COPY ##1 st_q.xf_st == asd_pkg::XF_IDLE);
	xoff_c: cover property ($rose(st_q.xoff_sent));
endmodule

/* asd_far_end.sv */
/*
 * Far-end terminal model: sends and takes characters on the line.
 * Assumes the bench clock and a fixed bit time of BAUD cycles.
 */
module asd_far_end #(
	parameter int BAUD = 4
) (
	// Bench clock
	input wire logic clk_in,
	// Line from the driver
	input wire logic txd_in,
	// Line to the driver, idle mark
	output logic rxd_out
);
	logic [7:0] got; // Last byte taken
	int got_n; // Bytes taken so far
	// Line idles at mark
	initial begin
		rxd_out = 1'b1;
		got_n = 0;
	end
	// Sends one character whenever the bench asks
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd_out <= f[i];
			repeat (BAUD) @(posedge clk_in);
		end
	endtask
	// Takes characters, sampling mid-bit
	always begin
		@(negedge txd_in);
		repeat (BAUD + BAUD / 2) @(posedge clk_in);
		for (int i = 0; i < 8; i++) begin
			got[i] = txd_in;
			repeat (BAUD) @(posedge clk_in);
		end
		got_n++;
	end
endmodule

/* testbench.sv */
/*
 * Self-checking bench for the serial character driver.
 * Assumes the far-end model and a 4-cycle bit time set over the bus.
 */
`include "asd_params.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, rd, wr, rxd, txd, wait_r;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, q;
	int n_fail, check_count;
	// Design with a short input buffer
	asd_serial_driver #(.IBUF_DEPTH(32), .XOFF_LEVEL(24)) dut (
		.CORE_CLK_IN(clk), .RESETN_IN(rst_n), .AVS_ADDRESS_IN(addr),
		.AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
		.AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_r),
		.RXD_IN(rxd), .TXD_OUT(txd));
	// Terminal on the line
	asd_far_end peer (.clk_in(clk), .txd_in(txd), .rxd_out(rxd));
	// Prints verdict and stops
	task finish_test;
		if (n_fail == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Compares seen against expected
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	// One bus access, held until waitrequest drops
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wait_r !== 1'b0 && n < 99);
		// A bus that never answers counts as a mismatch
		if (wait_r !== 1'b0) n_fail++;
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	// Reads a coordination byte until its permit clears
	task automatic poll(input logic [7:0] a);
		int n;
		n = 0;
		do begin
			bus(1'b0, a, 32'h0);
			n++;
		end while (q[7] !== 1'b0 && n < 3000);
		// A permit that never clears counts as a mismatch
		if (q[7] !== 1'b0) n_fail++;
	endtask
	// Reset values, read-only send code, unmapped place
	task test_regs;
		bus(1'b0, `ASD_OFS_CONFIG, 32'h0);
		chk("config", q, 32'h000DE801);
		bus(1'b0, `ASD_OFS_CHAR_DELAY, 32'h0);
		chk("delay", q, 32'h00000014);
		bus(1'b0, 8'hFC, 32'h0);
		chk("unmapped", q, 32'h0);
		bus(1'b1, `ASD_OFS_SEND_COORD, 32'h0000FF00);
		bus(1'b0, `ASD_OFS_SEND_COORD, 32'h0);
		chk("send_ro", q, 32'h0);
		bus(1'b1, `ASD_OFS_BAUD_DIV, 32'h4);
	endtask
	// Length word then one data byte out on the line
	task test_send;
		logic [7:0] m[3];
		m = '{8'h00, 8'h01, 8'h5A};
		bus(1'b1, `ASD_OFS_SMB_PTR, 32'h0);
		for (int i = 0; i < 3; i++) bus(1'b1, `ASD_OFS_SMB_DATA, {24'h0, m[i]});
		bus(1'b1, `ASD_OFS_SEND_COORD, 32'h80);
		poll(`ASD_OFS_SEND_COORD);
		chk("send_done", q[15:0], 16'h0000);
		repeat (8) @(posedge clk);
		chk("tx_byte", peer.got, 8'h5A);
		chk("tx_count", peer.got_n, 1);
	endtask
	// Buffered frame moved to the mailbox on request
	task test_recv;
		peer.send_byte(8'h41);
		peer.send_byte(8'h0D);
		bus(1'b1, `ASD_OFS_RECV_COORD, 32'h80);
		poll(`ASD_OFS_RECV_COORD);
		chk("recv_done", q[15:0], 16'h0000);
		bus(1'b0, `ASD_OFS_RMB_LEN, 32'h0);
		chk("rmb_len", q, 32'h2);
		bus(1'b0, `ASD_OFS_RMB_DATA, 32'h0);
		chk("rmb_0", q[7:0], 8'h41);
		bus(1'b0, `ASD_OFS_RMB_DATA, 32'h0);
		chk("rmb_1", q[7:0], 8'h0D);
	endtask
	// Mode 2 length from pointer, parity error, character delay
	task test_line;
		bus(1'b1, `ASD_OFS_CONFIG, 32'h000DE802);
		bus(1'b1, `ASD_OFS_SMB_PTR, 32'h0);
		bus(1'b1, `ASD_OFS_SMB_DATA, 32'h33);
		bus(1'b1, `ASD_OFS_SEND_COORD, 32'h80);
		poll(`ASD_OFS_SEND_COORD);
		repeat (8) @(posedge clk);
		chk("mode2_byte", peer.got, 8'h33);
		chk("mode2_count", peer.got_n, 2);
		// Even parity expected, none sent: the stop bit lands as a wrong parity bit
		bus(1'b1, `ASD_OFS_CONFIG, 32'h000DE811);
		bus(1'b1, `ASD_OFS_RECV_COORD, 32'h80);
		peer.send_byte(8'h41);
		poll(`ASD_OFS_RECV_COORD);
		chk("parity", q[15:0], 16'h0300);
		// No end character: the gap closes the frame and keeps it
		bus(1'b1, `ASD_OFS_CONFIG, 32'h000DE801);
		bus(1'b1, `ASD_OFS_RECV_COORD, 32'h80);
		peer.send_byte(8'h41);
		poll(`ASD_OFS_RECV_COORD);
		chk("delay_code", q[15:0], 16'h0100);
		bus(1'b1, `ASD_OFS_RECV_COORD, 32'h80);
		poll(`ASD_OFS_RECV_COORD);
		chk("delay_move", q[15:0], 16'h0000);
		bus(1'b0, `ASD_OFS_RMB_LEN, 32'h0);
		chk("delay_len", q, 32'h1);
		bus(1'b0, `ASD_OFS_RMB_DATA, 32'h0);
		chk("delay_data", q[7:0], 8'h41);
	endtask
	// Both mailboxes absent: error codes
	task test_errors;
		bus(1'b1, `ASD_OFS_CONFIG, 32'h000D2801);
		bus(1'b1, `ASD_OFS_SEND_COORD, 32'h80);
		poll(`ASD_OFS_SEND_COORD);
		chk("no_smb", q[15:0], 16'h1100);
		bus(1'b1, `ASD_OFS_RECV_COORD, 32'h80);
		peer.send_byte(8'h0D);
		poll(`ASD_OFS_RECV_COORD);
		chk("no_rmb", q[15:0], 16'h0F00);
	endtask
	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Main sequence
	initial begin
		rst_n = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		n_fail = 0;
		check_count = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		test_regs;
		test_send;
		test_recv;
		test_line;
		test_errors;
		finish_test;
	end
	// Watchdog, well beyond the expected several hundred cycles
	initial begin
		#200000;
		n_fail++;
		finish_test;
	end
endmodule
